// File: design/mbrt_cfg.svh
/*
 * Constants of the boot, reset, timestamp and I/O mode control block.
 * Assumes a 25 MHz reference clock; included by bare name.
 */
`ifndef MBRT_CFG_SVH
`define MBRT_CFG_SVH


//==========================================================
// Clock and timing
`define MBRT_CLK_HZ         25000000
`define MBRT_IMAGE_LOAD_MS  2000
`define MBRT_PARAM_LOAD_MS  1000
`define MBRT_BOOT_MAX_S     5
`define MBRT_TIME_RESP_MS   100
`define MBRT_RST_PULSE_US   125
`define MBRT_STROBE_MIN_US  125
`define MBRT_IMAGE_LOAD_CYC (`MBRT_IMAGE_LOAD_MS * (`MBRT_CLK_HZ / 1000))
`define MBRT_PARAM_LOAD_CYC (`MBRT_PARAM_LOAD_MS * (`MBRT_CLK_HZ / 1000))
`define MBRT_BOOT_MAX_CYC   (`MBRT_BOOT_MAX_S * `MBRT_CLK_HZ)

//==========================================================
// Serial commands and link settings
`define MBRT_CMD_RESET      8'h08
`define MBRT_CMD_DISCONNECT 8'h07
`define MBRT_BAUD_MODE1     9600
`define MBRT_BAUD_MODE3     115200
`define MBRT_DIV_MODE1      16'(`MBRT_CLK_HZ / `MBRT_BAUD_MODE1)
`define MBRT_DIV_MODE3      16'(`MBRT_CLK_HZ / `MBRT_BAUD_MODE3)
`define MBRT_DATA_BITS      4'h8
`define MBRT_TIME_W         32

`endif

// File: design/mbrt_pkg.sv
/*
 * Types of the boot, reset, timestamp and I/O mode control block.
 * Assumes nothing of its surroundings.
 */
package mbrt_pkg;
    typedef enum logic {MBRT_PKT_BOOT, MBRT_PKT_TIME} mbrt_pkt_t;
    typedef enum logic [1:0] {ST_IMAGE, ST_PARAMS, ST_ANNOUNCE, ST_RUN} mbrt_state_t;
endpackage

// File: design/mbrt_strobe_if.sv
/*
 * Synchronised timestamp strobe events between the strobe front end and the top.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/100ps
interface mbrt_strobe_if;
    logic fall;
    logic rise;
    logic level;
    modport src (output fall, rise, level);
    modport dst (input  fall, rise, level);
endinterface

// File: design/mbrt_strobe.sv
/*
 * Timestamp strobe front end: two-flop synchroniser and edge detector.
 * Assumes an asynchronous, idle-high strobe pin and a synchronised reset.
 */
`timescale 1ns/100ps
module mbrt_strobe (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst_sync_n,
    // Pin
    input  wire logic  time_strobe_n,
    // Events
    mbrt_strobe_if.src evt
);
    logic meta;
    logic sync;
    logic prev;
    logic fall;
    logic rise;

    //==========================================================
    // Synchroniser and edges
    wire next_fall = prev & ~sync;
    wire next_rise = ~prev & sync;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
            fall <= 1'b0;
            rise <= 1'b0;
        end else begin
            meta <= time_strobe_n;
            sync <= meta;
            prev <= sync;
            fall <= next_fall;
            rise <= next_rise;
        end
    end

    assign evt.fall  = fall;
    assign evt.rise  = rise;
    assign evt.level = prev;

    a_fall_after_sync: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        fall |-> !prev && $past(prev, 2)) else $error("strobe fall without synced edge");
endmodule

// File: design/mbrt_top.sv
/*
 * Boot, reset, timestamp and I/O mode control of a mesh module.
 * Assumes a serial packet engine on ref_clk that sends offered packets
 * and decodes host commands; pins come from an asynchronous host.
 */
`timescale 1ns/100ps
`include "mbrt_cfg.svh"
module mbrt_top import mbrt_pkg::*; #(
    parameter int unsigned IMAGE_CYC    = `MBRT_IMAGE_LOAD_CYC,
    parameter int unsigned PARAM_CYC    = `MBRT_PARAM_LOAD_CYC,
    parameter int unsigned BOOT_MAX_CYC = `MBRT_BOOT_MAX_CYC
) (
    // Clock and reset pin
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Host pins
    input  wire logic                    time_strobe_n,
    input  wire logic                    io_mode_sel,
    input  wire logic                    host_clear_to_send_n,
    output logic                         module_clear_to_send_n,
    output logic                         module_request_to_send_n,
    // Network and command side
    input  wire logic                    net_joined,
    input  wire logic                    rx_space,
    input  wire logic                    cmd_valid,
    input  wire logic [7:0]              cmd_code,
    input  wire logic                    read_time_req,
    // Serial engine
    input  wire logic                    tx_ready,
    output logic                         serial_ready,
    output logic                         mode3,
    output logic [15:0]                  baud_div,
    output logic                         byte_flow_en,
    output logic                         pkt_valid,
    output mbrt_pkt_t                    pkt_kind,
    output logic [`MBRT_TIME_W-1:0]      pkt_time
);
    function automatic logic at_limit(input logic [31:0] cnt, input int unsigned lim);
        at_limit = (cnt == 32'(lim - 1));
    endfunction

    //==========================================================
    // Reset release and pin synchronisers
    logic        rst_meta_n;
    logic        rst_sync_n;
    logic        mode_meta;
    logic        mode_sync;
    logic        hcts_meta;
    logic        hcts_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        mode_meta   <= io_mode_sel;
        mode_sync   <= mode_meta;
        hcts_meta   <= host_clear_to_send_n;
        hcts_sync_n <= hcts_meta;
    end

    mbrt_strobe_if evt ();

    mbrt_strobe u_strobe (
        .ref_clk       (ref_clk),
        .rst_sync_n    (rst_sync_n),
        .time_strobe_n (time_strobe_n),
        .evt           (evt)
    );

    //==========================================================
    // Decode
    mbrt_state_t             state;
    mbrt_state_t             next_state;
    logic [31:0]             cnt;
    logic [`MBRT_TIME_W-1:0] ts;
    logic [`MBRT_TIME_W-1:0] ts_hold;
    logic                    armed;
    logic                    time_pend;

    wire soft_rst  = cmd_valid && (cmd_code == `MBRT_CMD_RESET ||
                                   cmd_code == `MBRT_CMD_DISCONNECT);
    wire running   = (state == ST_RUN);
    wire taken     = pkt_valid && tx_ready && !hcts_sync_n;
    wire img_done  = (state == ST_IMAGE) && at_limit(cnt, IMAGE_CYC);
    wire par_done  = (state == ST_PARAMS) && at_limit(cnt, PARAM_CYC);
    wire strobe_ts = running && evt.fall;
    wire req_ts    = running && read_time_req;
    wire time_set  = req_ts || (running && evt.rise && armed);
    wire next_time_pend = time_set || (time_pend && !(taken && running));
    wire next_armed     = strobe_ts || (armed && !evt.rise);
    wire next_offer     = (next_state == ST_ANNOUNCE) ||
                          ((next_state == ST_RUN) && next_time_pend);
    wire next_cts_n     = !(running && net_joined && rx_space);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IMAGE:    if (img_done) next_state = ST_PARAMS;
            ST_PARAMS:   if (par_done) next_state = ST_ANNOUNCE;
            ST_ANNOUNCE: if (taken) next_state = ST_RUN;
            ST_RUN:      next_state = ST_RUN;
        endcase
        if (soft_rst) next_state = ST_IMAGE;
    end

    //==========================================================
    // Boot sequencer
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state        <= ST_IMAGE;
            cnt          <= 32'h0;
            serial_ready <= 1'b0;
        end else begin
            state        <= next_state;
            cnt          <= (next_state != state || soft_rst) ? 32'h0 : cnt + 32'h1;
            serial_ready <= (next_state == ST_ANNOUNCE) || (next_state == ST_RUN);
        end
    end

    //==========================================================
    // Mode strap, caught at boot start
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode3        <= 1'b0;
            baud_div     <= `MBRT_DIV_MODE1;
            byte_flow_en <= 1'b0;
        end else if (state == ST_IMAGE && cnt == 32'h0) begin
            mode3        <= mode_sync;
            baud_div     <= mode_sync ? `MBRT_DIV_MODE3 : `MBRT_DIV_MODE1;
            byte_flow_en <= mode_sync;
        end
    end

    //==========================================================
    // Timestamp capture and packet offer
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ts        <= '0;
            ts_hold   <= '0;
            armed     <= 1'b0;
            time_pend <= 1'b0;
        end else begin
            ts        <= ts + `MBRT_TIME_W'(1);
            ts_hold   <= (strobe_ts || req_ts) ? ts : ts_hold;
            armed     <= next_armed && !soft_rst;
            time_pend <= next_time_pend && !soft_rst;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pkt_valid                <= 1'b0;
            pkt_kind                 <= MBRT_PKT_BOOT;
            pkt_time                 <= '0;
            module_request_to_send_n <= 1'b1;
            module_clear_to_send_n   <= 1'b1;
        end else begin
            pkt_valid                <= next_offer;
            pkt_kind                 <= (next_state == ST_RUN) ? MBRT_PKT_TIME : MBRT_PKT_BOOT;
            pkt_time                 <= (strobe_ts || req_ts) ? ts : ts_hold;
            module_request_to_send_n <= !next_offer;
            module_clear_to_send_n   <= next_cts_n;
        end
    end

    //==========================================================
    // Checks
    logic [31:0] boot_age;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            boot_age <= 32'h0;
        end else begin
            boot_age <= (serial_ready || soft_rst) ? 32'h0 : boot_age + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    a_boot_max_time: assert property (boot_age < 32'(BOOT_MAX_CYC))
        else $error("serial not ready within boot limit");
    a_boot_order: assert property (state == ST_PARAMS |->
        $past(state) == ST_IMAGE || $past(state) == ST_PARAMS)
        else $error("parameters loaded before image");
    a_boot_event: assert property ($rose(serial_ready) |->
        pkt_valid && pkt_kind == MBRT_PKT_BOOT && state == ST_ANNOUNCE)
        else $error("boot event not offered at serial ready");
    a_cts_boot: assert property (state != ST_RUN |=> module_clear_to_send_n)
        else $error("clear to send active before run");
    a_cts_join: assert property (!net_joined |=> module_clear_to_send_n)
        else $error("clear to send active while not joined");
    a_soft_reset: assert property (soft_rst |=>
        state == ST_IMAGE && cnt == 32'h0 && !serial_ready && !pkt_valid)
        else $error("reset command did not restart boot");
    a_strobe_capture: assert property (strobe_ts |=> ##1 ts_hold == $past(ts, 2))
        else $error("strobe timestamp not captured");
    a_time_offer: assert property (time_set && !soft_rst |=>
        pkt_valid && pkt_kind == MBRT_PKT_TIME && !module_request_to_send_n)
        else $error("time packet not offered");
    a_mode_link: assert property (serial_ready |->
        byte_flow_en == mode3 &&
        baud_div == (mode3 ? `MBRT_DIV_MODE3 : `MBRT_DIV_MODE1))
        else $error("link settings disagree with mode");
    a_mode_stable: assert property (serial_ready && $past(serial_ready) |-> $stable(mode3))
        else $error("mode changed after boot");
    a_offer_hold: assert property (pkt_valid && !taken && !soft_rst |=>
        pkt_valid && $stable(pkt_kind))
        else $error("offered packet dropped before taken");
    a_strobe_pair: assert property (running && evt.rise && armed && !req_ts
        && !soft_rst |=> pkt_time == $past(ts_hold))
        else $error("strobe time packet lost its capture");
    a_strobe_level: assert property (evt.fall |-> !evt.level)
        else $error("strobe fall with high level");
    a_cts_space: assert property (!rx_space |=> module_clear_to_send_n)
        else $error("clear to send active without buffer space");
endmodule

// File: tb/mbrt_host_model.sv
/*
 * Host model: answers the module's request to send with clear to send.
 * Assumes ref_clk and the module's active-low handshake outputs.
 */
`timescale 1ns/100ps
module mbrt_host_model (
    // Clock
    input  wire logic ref_clk,
    // Handshake
    input  wire logic stall,
    input  wire logic module_request_to_send_n,
    output logic      host_clear_to_send_n
);
    // Ready only while a packet is requested and not stalled
    initial host_clear_to_send_n = 1'b1;
    always @(negedge ref_clk) begin
        host_clear_to_send_n <= module_request_to_send_n | stall;
    end
endmodule

// File: tb/testbench.sv
/*
 * Self-checking bench of the boot, reset, timestamp and mode control.
 * Assumes mbrt_top with shortened boot counts and the host model.
 */
`timescale 1ns/100ps
`include "mbrt_cfg.svh"
module testbench import mbrt_pkg::*;;
    typedef struct packed {logic sel; logic [7:0] cmd; logic m3; logic [15:0] div;} mbrt_row_t;
    logic ref_clk, rst_n, time_strobe_n, io_mode_sel, hcts_n, cts_n, rts_n, stall;
    logic net_joined, rx_space, cmd_valid, read_time_req, tx_ready;
    logic serial_ready, mode3, byte_flow_en, pkt_valid;
    logic [7:0] cmd_code;
    logic [15:0] baud_div;
    logic [`MBRT_TIME_W-1:0] pkt_time, t1, t2;
    mbrt_pkt_t pkt_kind;
    int failures, n_compared, cyc, f1, f2;
    mbrt_row_t rows [4] = '{'{1'b0, 8'h08, 1'b0, 16'h0A2C}, '{1'b1, 8'h08, 1'b1, 16'h00D9},
                            '{1'b1, 8'h07, 1'b1, 16'h00D9}, '{1'b0, 8'h07, 1'b0, 16'h0A2C}};

    mbrt_top #(.IMAGE_CYC(20), .PARAM_CYC(10), .BOOT_MAX_CYC(100)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .time_strobe_n(time_strobe_n),
        .io_mode_sel(io_mode_sel), .host_clear_to_send_n(hcts_n),
        .module_clear_to_send_n(cts_n), .module_request_to_send_n(rts_n),
        .net_joined(net_joined), .rx_space(rx_space), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .read_time_req(read_time_req), .tx_ready(tx_ready),
        .serial_ready(serial_ready), .mode3(mode3), .baud_div(baud_div),
        .byte_flow_en(byte_flow_en), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind),
        .pkt_time(pkt_time));
    mbrt_host_model host (.ref_clk(ref_clk), .stall(stall),
        .module_request_to_send_n(rts_n), .host_clear_to_send_n(hcts_n));

    //==========================================================
    // Clock, cycle count, watchdog
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end

    //==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic results;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic send_cmd(input logic [7:0] c);
        cmd_valid = 1'b1;
        cmd_code = c;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic await_boot;
        int n;
        n = 0;
        while (serial_ready !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(n inside {[28:36]}), 32'h1, "boot time");
        chk(pkt_valid, 32'h1, "boot offer");
        chk(rts_n, 32'h0, "boot request");
        chk(32'(pkt_kind), 32'(MBRT_PKT_BOOT), "boot kind");
    endtask
    task automatic wait_time(input int lim, output logic [31:0] t);
        int n;
        n = 0;
        while (!(pkt_valid === 1'b1 && pkt_kind === MBRT_PKT_TIME) && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        t = pkt_time;
        chk(32'(n < lim), 32'h1, "time offer");
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic strobe(output logic [31:0] t, output int f);
        time_strobe_n = 1'b0;
        f = cyc;
        repeat (3125) @(negedge ref_clk);
        time_strobe_n = 1'b1;
        wait_time(10, t);
    endtask

    //==========================================================
    // Sequence
    initial begin
        rst_n = 1'b0;
        time_strobe_n = 1'b1;
        io_mode_sel = 1'b0;
        stall = 1'b1;
        net_joined = 1'b0;
        rx_space = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        read_time_req = 1'b0;
        tx_ready = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(cts_n, 32'h1, "cts in reset");
        chk(serial_ready, 32'h0, "ready in reset");
        rst_n = 1'b1;
        await_boot();
        repeat (10) @(negedge ref_clk);
        chk(pkt_valid, 32'h1, "stalled offer");
        stall = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(pkt_valid, 32'h0, "offer taken");
        chk(rts_n, 32'h1, "request released");
        foreach (rows[i]) begin
            io_mode_sel = rows[i].sel;
            repeat (4) @(negedge ref_clk);
            send_cmd(rows[i].cmd);
            chk(serial_ready, 32'h0, "soft reset");
            await_boot();
            chk(mode3, rows[i].m3, "mode");
            chk(baud_div, rows[i].div, "divider");
            chk(byte_flow_en, rows[i].m3, "byte flow");
        end
        send_cmd(8'h05);
        repeat (3) @(negedge ref_clk);
        chk(serial_ready, 32'h1, "other code");
        chk(cts_n, 32'h1, "cts before join");
        net_joined = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(cts_n, 32'h0, "cts joined");
        rx_space = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(cts_n, 32'h1, "cts no space");
        rx_space = 1'b1;
        read_time_req = 1'b1;
        @(negedge ref_clk);
        read_time_req = 1'b0;
        wait_time(3, t1);
        strobe(t1, f1);
        repeat (50) @(negedge ref_clk);
        strobe(t2, f2);
        chk(t2 - t1, 32'(f2 - f1), "capture spacing");
        rst_n = 1'b0;
        repeat (3125) @(negedge ref_clk);
        chk(serial_ready, 32'h0, "held in reset");
        chk(cts_n, 32'h1, "cts held");
        rst_n = 1'b1;
        await_boot();
        results();
    end
endmodule
